// *** hdl/tq_pkg.sv ***
package tq_pkg;
   localparam int unsigned NCH = 4;
   // channel indices
   localparam int CH0 = 0;
   localparam int CH1 = 1;
   localparam int CHY = 2;
   localparam int CHX = 3;
   // register byte offsets
   localparam logic [7:0] A_COUNT01  = 8'h00;
   localparam logic [7:0] A_CMPA01   = 8'h04;
   localparam logic [7:0] A_CMPB01   = 8'h08;
   localparam logic [7:0] A_CTRL0    = 8'h0C;
   localparam logic [7:0] A_CTRL1    = 8'h10;
   localparam logic [7:0] A_COUNT_BK = 8'h14;
   localparam logic [7:0] A_CMPA_BK  = 8'h18;
   localparam logic [7:0] A_CMPB_BK  = 8'h1C;
   localparam logic [7:0] A_CTRL_BK  = 8'h20;
   localparam logic [7:0] A_CONN     = 8'h24;
   localparam logic [7:0] A_STAT     = 8'h28;
   localparam logic [7:0] A_MASK     = 8'h2C;
   localparam logic [7:0] A_CAPT     = 8'h30;
   localparam logic [7:0] A_COUNT_XY = 8'h34;
   // channel_control fields
   localparam int F_CKS  = 0;
   localparam int F_CLR  = 3;
   localparam int F_OSA  = 5;
   localparam int F_OSB  = 7;
   localparam int F_PSEL = 9;
   localparam int CTRL_W = 10;
   // clock select codes
   localparam logic [2:0] CK_OFF  = 3'h0;
   localparam logic [2:0] CK_P1   = 3'h1;
   localparam logic [2:0] CK_P2   = 3'h2;
   localparam logic [2:0] CK_P3   = 3'h3;
   localparam logic [2:0] CK_CASC = 3'h4;
   localparam logic [2:0] CK_EXT  = 3'h5;
   // prescaler exponents, psel 0 / 1
   localparam logic [3:0] E1A = 4'h1;
   localparam logic [3:0] E1B = 4'h3;
   localparam logic [3:0] E2A = 4'h6;
   localparam logic [3:0] E2B = 4'h7;
   localparam logic [3:0] E3A = 4'hA;
   localparam logic [3:0] E3B = 4'hB;
   // clear select and output actions
   localparam logic [1:0] CL_A   = 2'h1;
   localparam logic [1:0] CL_B   = 2'h2;
   localparam logic [1:0] CL_EXT = 2'h3;
   localparam logic [1:0] OS_LOW = 2'h1;
   localparam logic [1:0] OS_HI  = 2'h2;
   localparam logic [1:0] OS_TOG = 2'h3;
   // status layout and reset values
   localparam int ST_PER  = 3;
   localparam int ST_A    = 0;
   localparam int ST_B    = 1;
   localparam int ST_WRAP = 2;
   localparam int ST_CAPT = 12;
   localparam int ST_W    = 13;
   localparam logic [7:0] CNT_RST = 8'h00;
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CMP_RST = 8'hFF;
   localparam logic [CTRL_W-1:0] CTRL_RST = 10'h000;
endpackage

// *** hdl/tq_timer.sv ***
// The AHB-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
// Contract
// - clock from six prescaled or external
// - clear on match A, B, external reset
// - output pin driven by both matches
// - cascade pairs into one 16-bit counter
// - lower channel counts upper match A
// - match A, B, wrap; capture on X
// - channel X captures its count
// - own pins on 0/1, shared on Y/X
// - bank bit selects Y (1) or X (0)
// - 8-bit readable writable up-counter
// - counter pair reads as one word
// - control fields steer clock and clear
// - wrap FF to 00 sets wrap flag
// - counters reset to zero
// - clear code 00/01/10/11 as documented
// - constant compare sets flag, resets FF
// - no compare while constant is written
module tq_timer
   import tq_pkg::*;
#(
   parameter int unsigned PSC_W = 11
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // external pins
   input  wire logic        ext_clock_pin_zero,
   input  wire logic        ext_reset_pin_zero,
   input  wire logic        ext_clock_pin_one,
   input  wire logic        ext_reset_pin_one,
   input  wire logic        shared_clk_rst_pin_upper,
   input  wire logic        shared_clk_rst_pin_capture,
   input  wire logic        capture_in_pin,
   // timer outputs and interrupt
   output logic             output_pin_zero,
   output logic             output_pin_one,
   output logic             output_pin_upper,
   output logic             output_pin_capture,
   output logic             irq
);

////////////////////////////////////////////////////////////////////////////////
// state

   logic [PSC_W-1:0]  psc_q;
   logic [6:0]        s1_q;
   logic [6:0]        s2_q;
   logic [6:0]        s3_q;
   logic              dw_q;
   logic [7:0]        da_q;
   logic [31:0]       rd_q;
   logic [31:0]       rmux;
   logic [7:0]        cnt_q  [NCH];
   logic [7:0]        cnt_d  [NCH];
   logic [7:0]        cmpa_q [NCH];
   logic [7:0]        cmpb_q [NCH];
   logic [7:0]        wl     [NCH];
   logic [CTRL_W-1:0] ctrl_q [NCH];
   logic [NCH-1:0]    out_q;
   logic [NCH-1:0]    out_d;
   logic [NCH-1:0]    eqa;
   logic [NCH-1:0]    eqb;
   logic [NCH-1:0]    eqa_q;
   logic [NCH-1:0]    eqb_q;
   logic [NCH-1:0]    mta;
   logic [NCH-1:0]    mtb;
   logic [NCH-1:0]    inc;
   logic [NCH-1:0]    clr;
   logic [NCH-1:0]    wrp;
   logic [NCH-1:0]    w_cnt;
   logic [NCH-1:0]    w_ca;
   logic [NCH-1:0]    w_cb;
   logic [NCH-1:0]    w_ct;
   logic [ST_W-1:0]   st_set;
   logic [ST_W-1:0]   stat_q;
   logic [ST_W-1:0]   stat_d;
   logic [ST_W-1:0]   mask_q;
   logic              bank_q;
   logic [7:0]        capt_q;

////////////////////////////////////////////////////////////////////////////////
// functions

   function automatic logic hit(input logic [7:0] a, input logic [7:0] pa,
                                input logic [7:0] ba, input int i, input logic bk);
      hit = (i < 2) ? (a == pa) : ((a == ba) && (bk == (i == CHY)));
   endfunction

   function automatic logic tick(input logic [2:0] cks, input logic ps,
                                 input logic [PSC_W-1:0] p);
      logic [3:0]       e;
      logic [PSC_W-1:0] m;
      case (cks)
         CK_P1:   e = ps ? E1B : E1A;
         CK_P2:   e = ps ? E2B : E2A;
         CK_P3:   e = ps ? E3B : E3A;
         default: e = 4'h0;
      endcase
      m = (PSC_W'(1) << e) - PSC_W'(1);
      tick = (e != 4'h0) && ((p & m) == m);
   endfunction

   function automatic logic act(input logic [1:0] os, input logic o);
      case (os)
         OS_LOW:  act = 1'b0;
         OS_HI:   act = 1'b1;
         OS_TOG:  act = ~o;
         default: act = o;
      endcase
   endfunction

////////////////////////////////////////////////////////////////////////////////
// pins and bus decode

   wire [6:0] pin_raw = {capture_in_pin, shared_clk_rst_pin_capture,
                         shared_clk_rst_pin_upper, ext_reset_pin_one,
                         ext_clock_pin_one, ext_reset_pin_zero, ext_clock_pin_zero};
   wire [6:0] rise    = s2_q & ~s3_q;
   wire [3:0] xclk    = {rise[5], rise[4], rise[2], rise[0]};
   wire [3:0] xrst    = {rise[5], rise[4], rise[3], rise[1]};
   wire       cap_evt = rise[6];
   wire       ap      = hsel & hready & htrans[1];
   wire       wr      = dw_q;
   wire [7:0] wa      = da_q;
   wire [1:0] bx      = bank_q ? 2'(CHY) : 2'(CHX);

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = rd_q;
   assign irq       = |(stat_q & mask_q);
   assign {output_pin_capture, output_pin_upper, output_pin_one, output_pin_zero} = out_q;
   assign st_set[ST_CAPT] = cap_evt;
   assign stat_d = (stat_q & ~((wr && wa == A_STAT) ? hwdata[ST_W-1:0] : '0)) | st_set;

   always_comb begin
      case (haddr)
         A_COUNT01:  rmux = 32'({cnt_q[CH0], cnt_q[CH1]});
         A_COUNT_XY: rmux = 32'({cnt_q[CHY], cnt_q[CHX]});
         A_CMPA01:   rmux = 32'({cmpa_q[CH0], cmpa_q[CH1]});
         A_CMPB01:   rmux = 32'({cmpb_q[CH0], cmpb_q[CH1]});
         A_CTRL0:    rmux = 32'(ctrl_q[CH0]);
         A_CTRL1:    rmux = 32'(ctrl_q[CH1]);
         A_COUNT_BK: rmux = 32'(cnt_q[bx]);
         A_CMPA_BK:  rmux = 32'(cmpa_q[bx]);
         A_CMPB_BK:  rmux = 32'(cmpb_q[bx]);
         A_CTRL_BK:  rmux = 32'(ctrl_q[bx]);
         A_CONN:     rmux = 32'(bank_q);
         A_STAT:     rmux = 32'(stat_q);
         A_MASK:     rmux = 32'(mask_q);
         A_CAPT:     rmux = 32'(capt_q);
         default:    rmux = 32'h0000_0000;
      endcase
   end

////////////////////////////////////////////////////////////////////////////////
// channels

   default clocking dc @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   for (genvar i = 0; i < NCH; i++) begin : g_ch
      localparam bit UP = (i % 2 == 0);
      localparam int P  = i ^ 1;
      wire [2:0] cks = ctrl_q[i][F_CKS +: 3];
      wire [1:0] cls = ctrl_q[i][F_CLR +: 2];
      wire [1:0] osa = ctrl_q[i][F_OSA +: 2];
      wire [1:0] osb = ctrl_q[i][F_OSB +: 2];
      wire       psl = ctrl_q[i][F_PSEL];
      wire       hi  = UP && (i < 2 || wa == A_COUNT_XY);

      assign wl[i]    = hi ? hwdata[15:8] : hwdata[7:0];
      assign w_cnt[i] = wr && (hit(wa, A_COUNT01, A_COUNT_BK, i, bank_q)
                               || (i >= 2 && wa == A_COUNT_XY));
      assign w_ca[i]  = wr && hit(wa, A_CMPA01, A_CMPA_BK, i, bank_q);
      assign w_cb[i]  = wr && hit(wa, A_CMPB01, A_CMPB_BK, i, bank_q);
      assign w_ct[i]  = wr && hit(wa, (i == CH0) ? A_CTRL0 : A_CTRL1, A_CTRL_BK, i, bank_q);
      assign eqa[i]   = (cnt_q[i] == cmpa_q[i]) && !w_ca[i];
      assign eqb[i]   = (cnt_q[i] == cmpb_q[i]) && !w_cb[i];
      assign mta[i]   = eqa[i] && !eqa_q[i];
      assign mtb[i]   = eqb[i] && !eqb_q[i];
      assign inc[i]   = (cks == CK_CASC) ? (UP ? wrp[P] : mta[P]) :
                        (cks == CK_EXT) ? xclk[i] : tick(cks, psl, psc_q);
      assign clr[i]   = (cls == CL_A && mta[i]) || (cls == CL_B && mtb[i])
                        || (cls == CL_EXT && xrst[i]);
      assign wrp[i]   = inc[i] && cnt_q[i] == CNT_MAX && !clr[i] && !w_cnt[i];
      assign cnt_d[i] = w_cnt[i] ? wl[i] : clr[i] ? CNT_RST :
                        inc[i] ? cnt_q[i] + 8'h01 : cnt_q[i];
      assign out_d[i] = mtb[i] ? act(osb, out_q[i]) :
                        mta[i] ? act(osa, out_q[i]) : out_q[i];
      assign st_set[ST_PER*i +: ST_PER] = {wrp[i], mtb[i], mta[i]};

      AST_RST_ZERO: assert property ($past(!rst_n) |-> cnt_q[i] == CNT_RST)
         else $error("counter not zero after reset");
      AST_WRAP_FLAG: assert property (wrp[i] |=> stat_q[ST_PER*i+ST_WRAP])
         else $error("wrap flag missing");
      AST_CLEAR_NOW: assert property (clr[i] && !w_cnt[i] |=> cnt_q[i] == CNT_RST)
         else $error("counter not cleared");
      AST_MATCH_FLAG: assert property (mta[i] ##1 1'b1 |-> stat_q[ST_PER*i+ST_A])
         else $error("match flag missing");
      AST_NO_CMP_WR: assert property (w_cb[i] |-> !mtb[i])
         else $error("compare during write");
      AST_COUNT_UP: assert property (inc[i] && !clr[i] && !w_cnt[i]
                                     |=> cnt_q[i] == $past(cnt_q[i]) + 8'h01)
         else $error("counter did not step");
      AST_TOGGLE: assert property (mta[i] && !mtb[i] && osa == OS_TOG
                                   |=> out_q[i] != $past(out_q[i]))
         else $error("output did not toggle");
      AST_EXT_CLEAR: assert property (cls == CL_EXT && xrst[i] && !w_cnt[i]
                                      |=> cnt_q[i] == CNT_RST)
         else $error("external reset did not clear");
      AST_NO_CLEAR: assert property (cls != CL_A && cls != CL_B && cls != CL_EXT
                                     && !inc[i] && !w_cnt[i] |=> $stable(cnt_q[i]))
         else $error("counter changed with clearing off");
      AST_WRITE_WINS: assert property (w_cnt[i] |=> cnt_q[i] == $past(wl[i]))
         else $error("counter write lost");
      AST_WRAP_ZERO: assert property (wrp[i] |=> cnt_q[i] == CNT_RST)
         else $error("wrap did not reach zero");
      AST_B_WINS: assert property (mta[i] && mtb[i] && osb == OS_LOW
                                   |=> !out_q[i])
         else $error("match b action lost");
   end

////////////////////////////////////////////////////////////////////////////////
// registers

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         psc_q <= '0;
         s1_q  <= '0;
         s2_q  <= '0;
         s3_q  <= '0;
         dw_q  <= 1'b0;
         da_q  <= 8'h00;
         rd_q  <= 32'h0000_0000;
      end else begin
         psc_q <= psc_q + PSC_W'(1);
         s1_q  <= pin_raw;
         s2_q  <= s1_q;
         s3_q  <= s2_q;
         dw_q  <= ap & hwrite;
         da_q  <= haddr;
         if (ap && !hwrite) begin
            rd_q <= rmux;
         end
      end
   end

   always_ff @(posedge clk) begin
      for (int k = 0; k < NCH; k++) begin
         if (!rst_n) begin
            cnt_q[k]  <= CNT_RST;
            cmpa_q[k] <= CMP_RST;
            cmpb_q[k] <= CMP_RST;
            ctrl_q[k] <= CTRL_RST;
         end else begin
            cnt_q[k] <= cnt_d[k];
            if (w_ca[k]) begin
               cmpa_q[k] <= wl[k];
            end
            if (w_cb[k]) begin
               cmpb_q[k] <= wl[k];
            end
            if (w_ct[k]) begin
               ctrl_q[k] <= hwdata[CTRL_W-1:0];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         eqa_q  <= '0;
         eqb_q  <= '0;
         out_q  <= '0;
         stat_q <= '0;
         mask_q <= '0;
         bank_q <= 1'b0;
         capt_q <= CNT_RST;
      end else begin
         eqa_q  <= eqa;
         eqb_q  <= eqb;
         out_q  <= out_d;
         stat_q <= stat_d;
         if (wr && wa == A_MASK) begin
            mask_q <= hwdata[ST_W-1:0];
         end
         if (wr && wa == A_CONN) begin
            bank_q <= hwdata[0];
         end
         if (cap_evt) begin
            capt_q <= cnt_q[CHX];
         end
      end
   end

////////////////////////////////////////////////////////////////////////////////
// checks

   AST_CAPTURE: assert property (cap_evt |=> capt_q == $past(cnt_q[CHX])
                                 && stat_q[ST_CAPT])
      else $error("capture lost");
   AST_BANK_READ: assert property (ap && !hwrite && haddr == A_COUNT_BK && bank_q
                                   |=> hrdata == 32'($past(cnt_q[CHY])))
      else $error("bank read wrong channel");
   AST_CASCADE: assert property (ctrl_q[CH0][F_CKS +: 3] == CK_CASC && wrp[CH1]
                                 && !clr[CH0] && !w_cnt[CH0]
                                 |=> cnt_q[CH0] == $past(cnt_q[CH0]) + 8'h01)
      else $error("upper did not follow lower wrap");
   AST_MATCH_COUNT: assert property (ctrl_q[CHX][F_CKS +: 3] == CK_CASC && mta[CHY]
                                     && !clr[CHX] && !w_cnt[CHX]
                                     |=> cnt_q[CHX] == $past(cnt_q[CHX]) + 8'h01)
      else $error("lower did not count upper match");
   AST_BANK_WRITE: assert property (wr && wa == A_COUNT_BK && !bank_q
                                    |=> cnt_q[CHX] == $past(hwdata[7:0]))
      else $error("bank write reached wrong channel");
   AST_PAIR_READ: assert property (ap && !hwrite && haddr == A_COUNT01
                                   |=> hrdata[15:0] == {$past(cnt_q[CH0]), $past(cnt_q[CH1])})
      else $error("pair read wrong");
   AST_CAPT_HOLD: assert property (!cap_evt |=> $stable(capt_q))
      else $error("capture changed without event");

   COV_CASCADE: cover property (ctrl_q[CH0][F_CKS +: 3] == CK_CASC && wrp[CH1]);
   COV_CAPTURE: cover property (cap_evt ##1 irq);
   COV_CLEAR_B: cover property (clr[CHY] && mtb[CHY]);
   COV_EXT_CLR: cover property (clr[CH0] && xrst[CH0]);
   COV_MATCH_CNT: cover property (ctrl_q[CH1][F_CKS +: 3] == CK_CASC && mta[CH0]);

endmodule

// *** tb/eight_bit_timer_quad_bench.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module eight_bit_timer_quad_bench;
   import tq_pkg::*;
   logic        clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, rd_v, irq;
   logic [7:0]  haddr;
   logic [1:0]  htrans;
   logic [31:0] hwdata, hrdata, e, m, seed, rv;
   logic        ck0, rs0, ck1, rs1, shu, shx, cap;
   logic        out0, out1, outy, outx;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   int          failures, checks;
   assign hready = hreadyout;
   tq_pins u_tq_pins (.clk(clk), .ext_clock_pin_zero(ck0), .ext_reset_pin_zero(rs0),
      .ext_clock_pin_one(ck1), .ext_reset_pin_one(rs1), .shared_clk_rst_pin_upper(shu),
      .shared_clk_rst_pin_capture(shx), .capture_in_pin(cap));
   tq_timer u_tq_timer (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ext_clock_pin_zero(ck0),
      .ext_reset_pin_zero(rs0), .ext_clock_pin_one(ck1), .ext_reset_pin_one(rs1),
      .shared_clk_rst_pin_upper(shu), .shared_clk_rst_pin_capture(shx),
      .capture_in_pin(cap), .output_pin_zero(out0), .output_pin_one(out1),
      .output_pin_upper(outy), .output_pin_capture(outx), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////
   // clock, bus master and helpers
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) failures++;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= 1'b1;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] mk);
      exp_q.push_back(ex & mk);
      msk_q.push_back(mk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= 1'b0;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      rd_v <= 1'b1;
      wait_rdy();
      rd_v <= 1'b0;
   endtask
   // read data checked against the oldest note
   always @(posedge clk) begin
      if (rd_v === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         `CHK("hrdata", e, hrdata & m)
      end
   end
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #240000;
      failures++;
      tally_and_finish();
   end
   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      haddr = 8'h00;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      rd_v = 1'b0;
      seed = 32'd59432;
      failures = 0;
      checks = 0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(A_COUNT01, 32'h0000, 32'hFFFF);
      rd(A_CMPA01, 32'hFFFF, 32'hFFFF);
      rd(A_CMPB01, 32'hFFFF, 32'hFFFF);
      rd(A_CTRL0, 32'h0, 32'hFFFFFFFF);
      rd(A_STAT, 32'h0, 32'hFFFFFFFF);
      rd(8'h3C, 32'h0, 32'hFFFFFFFF);
      `CHK("hresp", 1'b0, hresp)
      `CHK("output_pin_capture", 1'b0, outx)
      for (int i = 0; i < 4; i++) begin
         rv = xs();
         wr(A_COUNT01, rv);
         rd(A_COUNT01, rv, 32'hFFFF);
      end
      // clear on match A at a prescaled rate
      wr(A_MASK, 32'h8);
      wr(A_COUNT01, 32'h0);
      wr(A_CMPA01, 32'h0003);
      wr(A_CTRL1, 32'h0 | CK_P1 | (CL_A << F_CLR) | (OS_TOG << F_OSA));
      for (int i = 0; i < 6; i++) begin
         repeat (7) @(posedge clk);
         rd(A_COUNT01, 32'h0, 32'h00FC);
      end
      rd(A_STAT, 32'h8, 32'h8);
      `CHK("irq", 1'b1, irq)
      wr(A_CTRL1, 32'h0);
      wr(A_STAT, 32'h1FFF);
      rd(A_STAT, 32'h0, 32'hFFFFFFFF);
      `CHK("irq", 1'b0, irq)
      // ch0 external clock, wrap, external clear
      wr(A_COUNT01, 32'hFE00);
      wr(A_CTRL0, 32'h0 | CK_EXT | (OS_TOG << F_OSB));
      repeat (2) u_tq_pins.pulse(0, 4);
      rd(A_COUNT01, 32'h0000, 32'hFF00);
      `CHK("output_pin_zero", 1'b1, out0)
      rd(A_STAT, 32'h4, 32'h4);
      repeat (3) u_tq_pins.pulse(0, 8);
      rd(A_COUNT01, 32'h0300, 32'hFF00);
      wr(A_CTRL0, 32'h0 | CK_EXT | (CL_EXT << F_CLR));
      u_tq_pins.pulse(1, 4);
      rd(A_COUNT01, 32'h0000, 32'hFF00);
      // ch1 output high on A, low and clear on B
      wr(A_COUNT01, 32'h0);
      wr(A_CMPA01, 32'hFF01);
      wr(A_CMPB01, 32'hFF02);
      wr(A_CTRL1, 32'h0 | CK_EXT | (CL_B << F_CLR) | (OS_HI << F_OSA) | (OS_LOW << F_OSB));
      u_tq_pins.pulse(2, 4);
      `CHK("output_pin_one", 1'b1, out1)
      u_tq_pins.pulse(2, 4);
      `CHK("output_pin_one", 1'b0, out1)
      rd(A_COUNT01, 32'h0, 32'h00FF);
      // cascade: ch1 counts ch0 match A
      wr(A_COUNT01, 32'h0);
      wr(A_CMPA01, 32'h0101);
      wr(A_CTRL1, 32'h0 | CK_CASC);
      wr(A_CTRL0, 32'h0 | CK_EXT | (CL_A << F_CLR));
      repeat (3) u_tq_pins.pulse(0, 4);
      rd(A_COUNT01, 32'h0003, 32'hFFFF);
      // banked access, capture, shared pin
      wr(A_CONN, 32'h1);
      wr(A_COUNT_BK, 32'h55);
      wr(A_CONN, 32'h0);
      wr(A_COUNT_BK, 32'hAA);
      rd(A_COUNT_XY, 32'h55AA, 32'hFFFF);
      rd(A_COUNT_BK, 32'hAA, 32'hFF);
      wr(A_COUNT_XY, 32'h0042);
      u_tq_pins.pulse(6, 4);
      rd(A_CAPT, 32'h42, 32'hFF);
      rd(A_STAT, 32'h1000, 32'h1000);
      wr(A_CONN, 32'h1);
      wr(A_CMPA_BK, 32'h2);
      wr(A_CTRL_BK, 32'h0 | CK_EXT | (OS_HI << F_OSA));
      repeat (2) u_tq_pins.pulse(4, 4);
      rd(A_COUNT_XY, 32'h0200, 32'hFF00);
      `CHK("output_pin_upper", 1'b1, outy)
      repeat (4) @(posedge clk);
      tally_and_finish();
   end
endmodule

// *** tb/tq_pins.sv ***
`timescale 1ns/1ps
module tq_pins (
   // clock
   input  wire logic clk,
   // pins toward the timer
   output logic      ext_clock_pin_zero,
   output logic      ext_reset_pin_zero,
   output logic      ext_clock_pin_one,
   output logic      ext_reset_pin_one,
   output logic      shared_clk_rst_pin_upper,
   output logic      shared_clk_rst_pin_capture,
   output logic      capture_in_pin
);
   logic [6:0] pin_q = 7'h00;
   assign {capture_in_pin, shared_clk_rst_pin_capture, shared_clk_rst_pin_upper,
           ext_reset_pin_one, ext_clock_pin_one, ext_reset_pin_zero,
           ext_clock_pin_zero} = pin_q;
   ////////////////////////////////////////////////////////////////////////////
   // one rising edge, held n cycles high then 4 low
   task automatic pulse(input int k, input int n);
      @(posedge clk);
      pin_q[k] <= 1'b1;
      repeat (n) @(posedge clk);
      pin_q[k] <= 1'b0;
      repeat (4) @(posedge clk);
   endtask
endmodule
